// ---- cpu_model.sv ----
/*
  cpu core model: byte reads and writes on the plain strobe port.
  assumes its tasks are entered just after a falling edge of mclk.
*/
`timescale 1ns/1ps
module cpu_model (
  input  wire logic           mclk,
  input  wire logic [7:0]     cpu_rdata,
  input  wire serial_timer_control_pkg::win_sel_s periph_sel,
  output logic [23:0]         cpu_addr,
  output logic                cpu_rd,
  output logic                cpu_wr,
  output logic [7:0]          cpu_wdata
);
  initial begin
    cpu_addr  = 24'h000000;
    cpu_rd    = 1'b0;
    cpu_wr    = 1'b0;
    cpu_wdata = 8'h00;
  end

  // software never sets the reserved bit, so bit 2 is cleared here
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    cpu_addr  = a;
    cpu_wdata = d & ~(8'h01 << serial_timer_control_pkg::RSV_BIT);
    cpu_rd    = 1'b0;
    cpu_wr    = 1'b1;
    @(negedge mclk);
    cpu_wr    = 1'b0;
    cpu_wdata = ~cpu_wdata;
  endtask

  // strobe and address stay up after the access so reads may run back to back;
  // the next write drops the read strobe
  task automatic rd(input logic [23:0] a, output serial_timer_control_pkg::win_sel_s s,
                    output logic [7:0] d);
    cpu_addr = a;
    cpu_rd   = 1'b1;
    @(posedge mclk);
    s = periph_sel;
    @(negedge mclk);
    d = cpu_rdata;
  endtask
endmodule

// ---- port_roles.sv ----
/*
  port role selection per bus mode: which pins carry address, data,
  multiplexed address/data, bus control or clock.
  assumes direction register bits reset to zero outside this block.
*/
`timescale 1ns/1ps
module port_roles (
  input  wire serial_timer_control_pkg::bus_mode_e mode,
  input  wire logic [7:0]          ddr1,
  input  wire logic [7:0]          ddr2,
  input  wire logic                bus_width_select,
  input  wire logic                p96_clock_request,
  output serial_timer_control_pkg::port_role_s     role
);
  always_comb begin
    role = '0;
    unique case (mode)
      serial_timer_control_pkg::MODE_SINGLE: begin
        role = '0;
      end
      serial_timer_control_pkg::MODE_NORMAL: begin
        role.p1_addr_out = ddr1;                // see R15
        role.p2_addr_out = ddr2;                // see R15
        role.p3_data     = 1'b1;                // see R16
        role.p6_data     = !bus_width_select;   // see R17
        role.p9_ctrl     = 1'b1;                // see R16
        role.p96_clock   = p96_clock_request;   // see R21
      end
      serial_timer_control_pkg::MODE_MUX: begin
        // direction registers are ignored on the multiplexed ports
        role.p2_mux      = 1'b1;                // see R18
        role.p1_mux      = !bus_width_select;   // see R19
        role.p3_data     = 1'b0;                // see R20
        role.p6_data     = 1'b0;                // see R20
        role.p9_ctrl     = 1'b1;                // see R22
        role.p96_clock   = p96_clock_request;   // see R21
      end
      default: begin
        role = '0;
      end
    endcase
  end
endmodule

// ---- register_window_and_bus_mode_select.sv ----
/*
  serial timer control register (low five bits), peripheral window
  selection and port role selection for the mode 2 bus.
  assumes the cpu core drives one access per cycle on the system clock and
  that mode pins and the expansion enable come from the mode control register.
*/
// Operation
// R1 - select 0: serial unit 1 at FFFF88-89 and FFFF8E-8F
// R2 - select 1: two-wire unit 1 replaces serial unit 1 there
// R3 - select 0: serial unit 2 at FFFFA0-A1 and FFFFA6-A7
// R4 - select 1: pulse dac unit replaces serial unit 2 there
// R5 - select 1: two-wire unit 0 at FFFFD8-D9, DE-DF; else serial unit
// R6 - flash select 0: FFFE88-8F is reserved, no flash registers
// R7 - flash select 0: power and peripheral control at FFFF80-87
// R8 - flash select 1: flash control registers at FFFE88-8F
// R9 - flash select 1: FFFF80-87 becomes reserved
// R10 - software keeps reserved bit 2 at zero on writes
// R11 - clock source bits plus three prescale bits choose timer clock
// R12 - mode 2 gives 16 Mbyte advanced space with on-chip rom enabled
// R13 - reset gives single-chip; expansion enable needed for external space
// R14 - extended modes: ports 1 and 2 are inputs after reset
// R15 - normal extended: port 1/2 pin drives address when direction bit set
// R16 - normal extended: port 3 is data bus, port 9 bus control
// R17 - normal extended: port 6 is data bus when bus width select is 0
// R18 - multiplexed 8-bit: port 2 multiplexed, port 1 general port
// R19 - multiplexed 16-bit: ports 1 and 2 both multiplexed
// R20 - ports 3 and 6 data bus only in normal extended mode
// R21 - pin 96 input after reset, clock pin in extended modes; the code gives it the clock role only while p96_clock_request is set
// R22 - other port 9 pins default i/o, bus control in extended modes
// R23 - window select write takes effect for the very next access
`timescale 1ns/1ps
module register_window_and_bus_mode_select (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic [23:0]           cpu_addr,
  input  wire logic                  cpu_rd,
  input  wire logic                  cpu_wr,
  input  wire logic [7:0]            cpu_wdata,
  output logic [7:0]                 cpu_rdata,
  input  wire logic                  mode_extended,
  input  wire logic                  mode_multiplex,
  input  wire logic                  external_expansion_enable,
  input  wire logic                  bus_width_select,
  input  wire logic [7:0]            ddr1,
  input  wire logic [7:0]            ddr2,
  input  wire logic                  p96_clock_request,
  input  wire logic [2:0]            timer_prescale,
  output serial_timer_control_pkg::win_sel_s         periph_sel,
  output serial_timer_control_pkg::port_role_s       port_role,
  output serial_timer_control_pkg::timer_clk_s       timer_clock_sel,
  output serial_timer_control_pkg::bus_mode_e        bus_mode,
  output logic                       rom_enable,
  output logic                       external_access_ok
);

  logic [7:0]            ctrl_q;
  logic                  ctrl_hit;
  logic                  ctrl_wr;
  logic                  access;
  serial_timer_control_pkg::win_sel_s    sel_w;
  serial_timer_control_pkg::port_role_s  role_d;
  serial_timer_control_pkg::port_role_s  role_q;
  serial_timer_control_pkg::bus_mode_e   mode_d;
  serial_timer_control_pkg::bus_mode_e   mode_q;
  serial_timer_control_pkg::timer_clk_s  tclk_q;
  logic [7:0]            rdata_q;
  logic                  rom_q;

  assign ctrl_hit = cpu_addr == serial_timer_control_pkg::CTRL_ADDR;
  assign ctrl_wr  = cpu_wr && ctrl_hit;
  assign access   = cpu_rd || cpu_wr;

  // only the low five bits exist here; the upper field lives elsewhere
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= serial_timer_control_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      // bit 2 is stored as written; keeping it zero is up to software
      ctrl_q <= cpu_wdata & serial_timer_control_pkg::CTRL_WR_MASK;  // see R23 see R10
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (cpu_rd && ctrl_hit) begin
      rdata_q <= ctrl_q;
    end else begin
      rdata_q <= '0;
    end
  end
  assign cpu_rdata = rdata_q;

  // decode reads the flop directly so no extra cycle sits after a write
  window_decode u_decode (
    .addr                  (cpu_addr),
    .twowire_window_select (ctrl_q[serial_timer_control_pkg::TW_WIN_BIT]),
    .nvm_window_select     (ctrl_q[serial_timer_control_pkg::NVM_WIN_BIT]),
    .sel                   (sel_w)
  );
  assign periph_sel = access ? sel_w : '0;  // see R23

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tclk_q <= '0;
    end else begin
      tclk_q.source_hi <= ctrl_q[serial_timer_control_pkg::CLK_HI_BIT];  // see R11
      tclk_q.source_lo <= ctrl_q[serial_timer_control_pkg::CLK_LO_BIT];  // see R11
      tclk_q.prescale  <= timer_prescale;                // see R11
    end
  end
  assign timer_clock_sel = tclk_q;

  // without the expansion enable the part stays single-chip
  always_comb begin
    mode_d = serial_timer_control_pkg::MODE_SINGLE;
    if (mode_extended && external_expansion_enable) begin  // see R13
      mode_d = mode_multiplex ? serial_timer_control_pkg::MODE_MUX : serial_timer_control_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_q <= serial_timer_control_pkg::MODE_SINGLE;  // see R13
    end else begin
      mode_q <= mode_d;
    end
  end
  assign bus_mode           = mode_q;
  assign external_access_ok = mode_q != serial_timer_control_pkg::MODE_SINGLE;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rom_q <= 1'b0;
    end else begin
      rom_q <= 1'b1;  // see R12
    end
  end
  assign rom_enable = rom_q;

  port_roles u_roles (
    .mode              (mode_q),
    .ddr1              (ddr1),
    .ddr2              (ddr2),
    .bus_width_select  (bus_width_select),
    .p96_clock_request (p96_clock_request),
    .role              (role_d)
  );

  // reset clears every role so ports 1, 2 and pin 96 start as inputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      role_q <= '0;  // see R14 see R21 see R22
    end else begin
      role_q <= role_d;
    end
  end
  assign port_role = role_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic in_ser1;
  logic in_ser2;
  logic in_tw0;
  logic in_pwr;
  logic in_nvm;
  assign in_ser1 = (cpu_addr >= serial_timer_control_pkg::SER1_LO_BASE && cpu_addr <= serial_timer_control_pkg::SER1_LO_END) ||
                   (cpu_addr >= serial_timer_control_pkg::SER1_HI_BASE && cpu_addr <= serial_timer_control_pkg::SER1_HI_END);
  assign in_ser2 = (cpu_addr >= serial_timer_control_pkg::SER2_LO_BASE && cpu_addr <= serial_timer_control_pkg::SER2_LO_END) ||
                   (cpu_addr >= serial_timer_control_pkg::SER2_HI_BASE && cpu_addr <= serial_timer_control_pkg::SER2_HI_END);
  assign in_tw0  = (cpu_addr >= serial_timer_control_pkg::TW0_LO_BASE && cpu_addr <= serial_timer_control_pkg::TW0_LO_END) ||
                   (cpu_addr >= serial_timer_control_pkg::TW0_HI_BASE && cpu_addr <= serial_timer_control_pkg::TW0_HI_END);
  assign in_pwr  = cpu_addr >= serial_timer_control_pkg::PWR_BASE && cpu_addr <= serial_timer_control_pkg::PWR_END;
  assign in_nvm  = cpu_addr >= serial_timer_control_pkg::NVM_BASE && cpu_addr <= serial_timer_control_pkg::NVM_END;

  sequence write_tw_on;
    ctrl_wr && cpu_wdata[serial_timer_control_pkg::TW_WIN_BIT];
  endsequence

  sequence write_nvm_on;
    ctrl_wr && cpu_wdata[serial_timer_control_pkg::NVM_WIN_BIT];
  endsequence

  AST_SER1_WIN: assert property ( // see R1
    access && in_ser1 && !ctrl_q[serial_timer_control_pkg::TW_WIN_BIT]
      |-> periph_sel.serial_unit_1 && !periph_sel.twowire_unit_1)
    else $error("serial unit 1 window not decoded");

  AST_TW1_AFTER_WRITE: assert property ( // see R2
    write_tw_on ##1 (access && in_ser1) |-> periph_sel.twowire_unit_1)
    else $error("two-wire unit 1 not in serial unit 1 window after select");

  AST_SER2_WIN: assert property ( // see R3
    access && in_ser2 && !ctrl_q[serial_timer_control_pkg::TW_WIN_BIT]
      |-> periph_sel.serial_unit_2 && !periph_sel.pulse_dac_unit)
    else $error("serial unit 2 window not decoded");

  AST_PDAC_WIN: assert property ( // see R4
    access && in_ser2 && ctrl_q[serial_timer_control_pkg::TW_WIN_BIT]
      |-> periph_sel.pulse_dac_unit && !periph_sel.serial_unit_2)
    else $error("pulse dac window not decoded");

  AST_TW0_WIN: assert property ( // see R5
    access && in_tw0 |-> periph_sel.twowire_unit_0 == ctrl_q[serial_timer_control_pkg::TW_WIN_BIT]
      && periph_sel.serial_unit_0 == !ctrl_q[serial_timer_control_pkg::TW_WIN_BIT])
    else $error("two-wire unit 0 window wrong");

  AST_NVM_HOLE: assert property ( // see R6
    access && in_nvm && !ctrl_q[serial_timer_control_pkg::NVM_WIN_BIT]
      |-> periph_sel.reserved && !periph_sel.nvm_ctrl)
    else $error("flash window exposed while deselected");

  AST_PWR_WIN: assert property ( // see R7
    access && in_pwr && !ctrl_q[serial_timer_control_pkg::NVM_WIN_BIT] |-> periph_sel.power_ctrl)
    else $error("power control window not decoded");

  AST_NVM_AFTER_WRITE: assert property ( // see R8
    write_nvm_on ##1 (access && in_nvm) |-> periph_sel.nvm_ctrl)
    else $error("flash window not decoded after select");

  AST_PWR_HOLE: assert property ( // see R9
    access && in_pwr && ctrl_q[serial_timer_control_pkg::NVM_WIN_BIT]
      |-> periph_sel.reserved && !periph_sel.power_ctrl)
    else $error("power window not reserved with flash select");

  AST_TIMER_SRC: assert property ( // see R11
    ctrl_wr ##1 !ctrl_wr |-> ##1 timer_clock_sel.source_hi == $past(cpu_wdata[1], 2)
      && timer_clock_sel.source_lo == $past(cpu_wdata[0], 2))
    else $error("timer clock source does not follow register write");

  AST_ROM_ON: assert property ( // see R12
    $past(!sys_rst) |-> rom_enable)
    else $error("on-chip rom not enabled");

  AST_SINGLE_NO_EXP: assert property ( // see R13
    !external_expansion_enable |=> bus_mode == serial_timer_control_pkg::MODE_SINGLE && !external_access_ok)
    else $error("left single-chip mode without expansion enable");

  AST_SINGLE_INPUTS: assert property ( // see R14
    bus_mode == serial_timer_control_pkg::MODE_SINGLE |=> port_role.p1_addr_out == 8'h00
      && port_role.p2_addr_out == 8'h00 && !port_role.p1_mux && !port_role.p2_mux)
    else $error("ports 1 or 2 driven in single-chip mode");

  AST_NORMAL_ADDR: assert property ( // see R15
    bus_mode == serial_timer_control_pkg::MODE_NORMAL |=> port_role.p1_addr_out == $past(ddr1)
      && port_role.p2_addr_out == $past(ddr2))
    else $error("address pins do not follow direction bits");

  AST_NORMAL_DATA: assert property ( // see R16
    bus_mode == serial_timer_control_pkg::MODE_NORMAL |=> port_role.p3_data && port_role.p9_ctrl)
    else $error("port 3 or port 9 role missing in normal mode");

  AST_P6_WIDTH: assert property ( // see R17
    bus_mode == serial_timer_control_pkg::MODE_NORMAL |=> port_role.p6_data == !$past(bus_width_select))
    else $error("port 6 data role does not follow bus width");

  AST_MUX8: assert property ( // see R18
    bus_mode == serial_timer_control_pkg::MODE_MUX && bus_width_select |=> port_role.p2_mux
      && !port_role.p1_mux && port_role.p2_addr_out == 8'h00)
    else $error("8-bit multiplexed port roles wrong");

  AST_MUX16: assert property ( // see R19
    bus_mode == serial_timer_control_pkg::MODE_MUX && !bus_width_select |=> port_role.p1_mux
      && port_role.p2_mux)
    else $error("16-bit multiplexed port roles wrong");

  AST_MUX_PLAIN: assert property ( // see R20
    bus_mode != serial_timer_control_pkg::MODE_NORMAL |=> !port_role.p3_data && !port_role.p6_data)
    else $error("port 3 or 6 data role outside normal mode");

  AST_P96_CLOCK: assert property ( // see R21
    bus_mode == serial_timer_control_pkg::MODE_SINGLE |=> !port_role.p96_clock)
    else $error("pin 96 clock role in single-chip mode");

  AST_P9_CTRL: assert property ( // see R22
    bus_mode != serial_timer_control_pkg::MODE_SINGLE |=> port_role.p9_ctrl)
    else $error("port 9 bus control missing in extended mode");

  AST_WIN_NEXT: assert property ( // see R23
    ctrl_wr |=> ctrl_q[4:3] == $past(cpu_wdata[4:3]))
    else $error("window select not updated in one cycle");

endmodule

// ---- register_window_and_bus_mode_select_tb.sv ----
/*
  testbench for the register window and bus mode block: reset values,
  register access, window decode, timer clock selection and port roles.
  assumes the cpu model of cpu_model.sv and a 100 MHz clock.
*/
`timescale 1ns/1ps
module register_window_and_bus_mode_select_tb;
  logic                 mclk;
  logic                 sys_rst;
  logic [23:0]          cpu_addr;
  logic                 cpu_rd;
  logic                 cpu_wr;
  logic [7:0]           cpu_wdata;
  logic [7:0]           cpu_rdata;
  logic                 mode_extended;
  logic                 mode_multiplex;
  logic                 external_expansion_enable;
  logic                 bus_width_select;
  logic [7:0]           ddr1;
  logic [7:0]           ddr2;
  logic                 p96_clock_request;
  logic [2:0]           timer_prescale;
  serial_timer_control_pkg::win_sel_s   periph_sel;
  serial_timer_control_pkg::port_role_s port_role;
  serial_timer_control_pkg::timer_clk_s timer_clock_sel;
  serial_timer_control_pkg::bus_mode_e  bus_mode;
  logic                 rom_enable;
  logic                 external_access_ok;
  int                   err_count;
  int                   n_tests;

  register_window_and_bus_mode_select register_window_and_bus_mode_select_i (
    .mclk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .mode_extended, .mode_multiplex, .external_expansion_enable,
    .bus_width_select, .ddr1, .ddr2, .p96_clock_request, .timer_prescale,
    .periph_sel, .port_role, .timer_clock_sel, .bus_mode, .rom_enable,
    .external_access_ok
  );

  cpu_model cpu_model_i (
    .mclk, .cpu_rdata, .periph_sel, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata
  );

  always #5 mclk = ~mclk;

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic cmp_vec(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    return a >= lo && a <= hi;
  endfunction

  function automatic serial_timer_control_pkg::win_sel_s exp_sel(input logic [23:0] a, input logic tw,
                                                 input logic nv);
    serial_timer_control_pkg::win_sel_s s;
    logic               s1;
    logic               s2;
    logic               t0;
    logic               pw;
    logic               fl;
    s1 = in_rng(a, 24'hFFFF88, 24'hFFFF89) || in_rng(a, 24'hFFFF8E, 24'hFFFF8F);
    s2 = in_rng(a, 24'hFFFFA0, 24'hFFFFA1) || in_rng(a, 24'hFFFFA6, 24'hFFFFA7);
    t0 = in_rng(a, 24'hFFFFD8, 24'hFFFFD9) || in_rng(a, 24'hFFFFDE, 24'hFFFFDF);
    pw = in_rng(a, 24'hFFFF80, 24'hFFFF87);
    fl = in_rng(a, 24'hFFFE88, 24'hFFFE8F);
    s.serial_unit_1  = s1 & !tw;
    s.twowire_unit_1 = s1 & tw;
    s.serial_unit_2  = s2 & !tw;
    s.pulse_dac_unit = s2 & tw;
    s.twowire_unit_0 = t0 & tw;
    s.serial_unit_0  = t0 & !tw;
    s.power_ctrl     = pw & !nv;
    s.nvm_ctrl       = fl & nv;
    s.reserved       = (fl & !nv) | (pw & nv);
    return s;
  endfunction

  task automatic t_reset();
    serial_timer_control_pkg::win_sel_s s;
    logic [7:0]         d;
    cmp_vec("port_role", 24'h000000, 24'(port_role));
    cmp_byte("bus_mode", 8'h00, 8'(bus_mode));
    cpu_model_i.rd(24'hFFFFC0, s, d);
    cmp_byte("reset value", 8'h00, d);
    cmp_vec("port_role idle", 24'h000000, 24'(port_role));
    cmp_byte("rom_enable", 8'h01, 8'(rom_enable));
    cmp_byte("access_ok", 8'h00, 8'(external_access_ok));
  endtask

  task automatic t_reg();
    serial_timer_control_pkg::win_sel_s s;
    logic [7:0]         d;
    cpu_model_i.wr(24'hFFFFC0, 8'hFF);
    cpu_model_i.rd(24'hFFFFC0, s, d);
    cmp_byte("register", 8'h1B, d);
    cpu_model_i.wr(24'hFFFFC1, 8'h00);
    cpu_model_i.rd(24'hFFFFC0, s, d);
    cmp_byte("register kept", 8'h1B, d);
    cpu_model_i.rd(24'hFFFFC1, s, d);
    cmp_byte("unmapped", 8'h00, d);
  endtask

  // first probe after each write lands in the very next cycle
  task automatic t_windows();
    logic [23:0]        addrs [12];
    logic [23:0]        a;
    serial_timer_control_pkg::win_sel_s s;
    logic [7:0]         d;
    addrs = '{24'hFFFF88, 24'hFFFF8F, 24'hFFFFA1, 24'hFFFFA6, 24'hFFFFA7, 24'hFFFFD9,
              24'hFFFFDE, 24'hFFFF80, 24'hFFFF87, 24'hFFFE88, 24'hFFFE8F, 24'hFFFF8A};
    for (int m = 0; m < 4; m++) begin
      cpu_model_i.wr(24'hFFFFC0, 8'(m << 3));
      // flash select writes probe the flash window first, the rest serial unit 1
      for (int k = 0; k < 12; k++) begin
        a = addrs[(k + (m[0] ? 9 : 0)) % 12];
        cpu_model_i.rd(a, s, d);
        cmp_vec("sel", 24'(exp_sel(a, m[1], m[0])), 24'(s));
        cmp_byte("window rdata", 8'h00, d);
      end
    end
  endtask

  task automatic t_timer();
    for (int i = 0; i < 4; i++) begin
      timer_prescale = 3'(7 - i);
      cpu_model_i.wr(24'hFFFFC0, 8'(i));
      @(negedge mclk);
      cmp_vec("timer_sel", {19'h00000, i[1], i[0], 3'(7 - i)}, 24'(timer_clock_sel));
    end
  endtask

  task automatic t_mode(input logic ext, input logic mux, input logic en, input logic bw);
    serial_timer_control_pkg::port_role_s r;
    logic                 nrm;
    logic                 mx;
    mode_extended             = ext;
    mode_multiplex            = mux;
    external_expansion_enable = en;
    bus_width_select          = bw;
    ddr1                      = ~ddr1;
    ddr2                      = ddr2 + 8'h11;
    p96_clock_request         = !bw;
    repeat (3) @(negedge mclk);
    nrm           = ext & en & !mux;
    mx            = ext & en & mux;
    r.p1_addr_out = nrm ? ddr1 : 8'h00;
    r.p2_addr_out = nrm ? ddr2 : 8'h00;
    r.p1_mux      = mx & !bw;
    r.p2_mux      = mx;
    r.p3_data     = nrm;
    r.p6_data     = nrm & !bw;
    r.p9_ctrl     = nrm | mx;
    r.p96_clock   = (nrm | mx) & !bw;
    cmp_byte("bus_mode", {6'h00, mx, nrm}, 8'(bus_mode));
    cmp_vec("port_role", 24'(r), 24'(port_role));
    cmp_byte("access_ok", 8'(nrm | mx), 8'(external_access_ok));
  endtask

  task automatic t_modes();
    t_mode(1'b1, 1'b0, 1'b1, 1'b0);
    t_mode(1'b1, 1'b0, 1'b1, 1'b1);
    t_mode(1'b1, 1'b1, 1'b1, 1'b1);
    t_mode(1'b1, 1'b1, 1'b1, 1'b0);
    t_mode(1'b1, 1'b0, 1'b0, 1'b0);
    t_mode(1'b0, 1'b1, 1'b1, 1'b1);
  endtask

  initial begin
    mclk                      = 1'b0;
    sys_rst                   = 1'b1;
    // extended mode pins from the start: ports must still come up as inputs
    mode_extended             = 1'b1;
    mode_multiplex            = 1'b0;
    external_expansion_enable = 1'b0;
    bus_width_select          = 1'b0;
    ddr1                      = 8'h5A;
    ddr2                      = 8'h3C;
    p96_clock_request         = 1'b0;
    timer_prescale            = 3'h0;
    err_count                 = 0;
    n_tests                   = 0;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_reg();
    t_windows();
    t_timer();
    t_modes();
    test_done();
  end

  // a hung run is cut short and counted as a mismatch
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule

// ---- serial_timer_control_pkg.sv ----
/*
  package for the register window and bus mode block: addresses, field
  positions, reset values, mode codes and the structs carried between modules.
  assumes a 24-bit cpu address and an 8-bit register data path.
*/
package serial_timer_control_pkg;

  localparam int          ADDR_W        = 24;
  localparam int          DATA_W        = 8;
  // one byte register; its address is a local choice
  localparam logic [23:0] CTRL_ADDR     = 24'hFFFFC0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK  = 8'h1F;
  localparam int          TW_WIN_BIT    = 4;
  localparam int          NVM_WIN_BIT   = 3;
  localparam int          RSV_BIT       = 2;
  localparam int          CLK_HI_BIT    = 1;
  localparam int          CLK_LO_BIT    = 0;

  localparam logic [23:0] SER1_LO_BASE  = 24'hFFFF88;
  localparam logic [23:0] SER1_LO_END   = 24'hFFFF89;
  localparam logic [23:0] SER1_HI_BASE  = 24'hFFFF8E;
  localparam logic [23:0] SER1_HI_END   = 24'hFFFF8F;
  localparam logic [23:0] SER2_LO_BASE  = 24'hFFFFA0;
  localparam logic [23:0] SER2_LO_END   = 24'hFFFFA1;
  localparam logic [23:0] SER2_HI_BASE  = 24'hFFFFA6;
  localparam logic [23:0] SER2_HI_END   = 24'hFFFFA7;
  localparam logic [23:0] TW0_LO_BASE   = 24'hFFFFD8;
  localparam logic [23:0] TW0_LO_END    = 24'hFFFFD9;
  localparam logic [23:0] TW0_HI_BASE   = 24'hFFFFDE;
  localparam logic [23:0] TW0_HI_END    = 24'hFFFFDF;
  localparam logic [23:0] PWR_BASE      = 24'hFFFF80;
  localparam logic [23:0] PWR_END       = 24'hFFFF87;
  localparam logic [23:0] NVM_BASE      = 24'hFFFE88;
  localparam logic [23:0] NVM_END       = 24'hFFFE8F;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_MUX    = 2'b10
  } bus_mode_e;

  typedef struct packed {
    logic serial_unit_1;
    logic twowire_unit_1;
    logic serial_unit_2;
    logic pulse_dac_unit;
    logic twowire_unit_0;
    logic serial_unit_0;
    logic power_ctrl;
    logic nvm_ctrl;
    logic reserved;
  } win_sel_s;

  typedef struct packed {
    logic [7:0] p1_addr_out;
    logic [7:0] p2_addr_out;
    logic       p1_mux;
    logic       p2_mux;
    logic       p3_data;
    logic       p6_data;
    logic       p9_ctrl;
    logic       p96_clock;
  } port_role_s;

  typedef struct packed {
    logic       source_hi;
    logic       source_lo;
    logic [2:0] prescale;
  } timer_clk_s;

endpackage

// ---- window_decode.sv ----
/*
  address window decoder: picks which peripheral register set answers an
  address, steered by the two window select bits.
  assumes the select bits are stable flops of the caller.
*/
`timescale 1ns/1ps
module window_decode (
  input  wire logic [23:0]        addr,
  input  wire logic               twowire_window_select,
  input  wire logic               nvm_window_select,
  output serial_timer_control_pkg::win_sel_s      sel
);
  logic ser1_w;
  logic ser2_w;
  logic tw0_w;
  logic pwr_w;
  logic nvm_w;

  assign ser1_w = (addr >= serial_timer_control_pkg::SER1_LO_BASE && addr <= serial_timer_control_pkg::SER1_LO_END) ||
                  (addr >= serial_timer_control_pkg::SER1_HI_BASE && addr <= serial_timer_control_pkg::SER1_HI_END);
  assign ser2_w = (addr >= serial_timer_control_pkg::SER2_LO_BASE && addr <= serial_timer_control_pkg::SER2_LO_END) ||
                  (addr >= serial_timer_control_pkg::SER2_HI_BASE && addr <= serial_timer_control_pkg::SER2_HI_END);
  assign tw0_w  = (addr >= serial_timer_control_pkg::TW0_LO_BASE && addr <= serial_timer_control_pkg::TW0_LO_END) ||
                  (addr >= serial_timer_control_pkg::TW0_HI_BASE && addr <= serial_timer_control_pkg::TW0_HI_END);
  assign pwr_w  = addr >= serial_timer_control_pkg::PWR_BASE && addr <= serial_timer_control_pkg::PWR_END;
  assign nvm_w  = addr >= serial_timer_control_pkg::NVM_BASE && addr <= serial_timer_control_pkg::NVM_END;

  always_comb begin
    sel                = '0;
    sel.serial_unit_1  = ser1_w && !twowire_window_select;  // see R1
    sel.twowire_unit_1 = ser1_w && twowire_window_select;   // see R2
    sel.serial_unit_2  = ser2_w && !twowire_window_select;  // see R3
    sel.pulse_dac_unit = ser2_w && twowire_window_select;   // see R4
    sel.twowire_unit_0 = tw0_w && twowire_window_select;    // see R5
    sel.serial_unit_0  = tw0_w && !twowire_window_select;   // see R5
    sel.power_ctrl     = pwr_w && !nvm_window_select;       // see R7
    sel.nvm_ctrl       = nvm_w && nvm_window_select;        // see R8
    // whichever of the flash and power windows is switched away reads as a hole
    sel.reserved       = (nvm_w && !nvm_window_select) ||   // see R6
                         (pwr_w && nvm_window_select);      // see R9
  end
endmodule
